//--- logic/adcctl_pkg.sv
package adcctl_pkg;

    // memory-mapped offsets on the core's internal bus
    localparam logic [7:0] ADCCTL_PRIMARY_OFS = 8'h9f;
    localparam logic [7:0] ADCCTL_CONFIG_OFS = 8'ha0;
    localparam logic [7:0] ADCCTL_RESULT_OFS = 8'ha1;

    // primary control fields
    localparam int ADCCTL_PEND_BIT = 7;
    localparam int ADCCTL_IRQEN_BIT = 6;
    localparam int ADCCTL_START_BIT = 5;
    localparam int ADCCTL_REF_BIT = 4;
    localparam int ADCCTL_CHAN_LSB = 0;
    localparam int ADCCTL_CHAN_W = 4;

    // analog configuration fields
    localparam int ADCCTL_REFHALF_BIT = 7;
    localparam int ADCCTL_CMPSEL_BIT = 6;
    localparam int ADCCTL_AMP_BIT = 5;
    localparam int ADCCTL_AUTO_BIT = 4;
    localparam int ADCCTL_DIV_LSB = 2;
    localparam int ADCCTL_ISRC_BIT = 1;
    localparam int ADCCTL_AZ_BIT = 0;

    // reset values
    localparam logic [7:0] ADCCTL_PRIMARY_RST = 8'h00;
    localparam logic [7:0] ADCCTL_CONFIG_RST = 8'h00;
    localparam logic [7:0] ADCCTL_RESULT_RST = 8'h00;
    localparam logic [7:0] ADCCTL_UNMAPPED_RD = 8'h00;

    // conversion lengths in conversion clock cycles
    localparam logic [4:0] ADCCTL_STD_CYCLES = 5'h0d;
    localparam logic [4:0] ADCCTL_AZ_CYCLES = 5'h14;

    // channel codes
    localparam logic [3:0] ADCCTL_CH_ONE = 4'h0;
    localparam logic [3:0] ADCCTL_CH_FIVE = 4'h8;
    localparam logic [3:0] ADCCTL_CH_GND = 4'h9;
    localparam logic [3:0] ADCCTL_CH_BANDGAP = 4'ha;
    localparam logic [3:0] ADCCTL_CH_VCC3 = 4'hc;

endpackage

//--- logic/adcctl_top.sv
module adcctl_top
    import adcctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    output logic [7:0] mem_rdata_o,
    input wire logic pwm_sample_strobe_i,
    input wire logic timer_clk_tick_i,
    input wire logic [7:0] conv_data_i,
    output logic conv_done_interrupt_o,
    output logic conv_active_o,
    output logic ref_voltage_select_o,
    output logic [3:0] input_channel_select_o,
    output logic ref_clock_halve_o,
    output logic comparator_input_select_o,
    output logic spare_amp_enable_o,
    output logic current_source_enable_o,
    output logic autozero_enable_o,
    output logic auto_sample_enable_o
);

    function automatic logic [2:0] div_mask(input logic [1:0] sel);
        case (sel)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction

    logic pending_r;
    logic irq_en_r;
    logic busy_r;
    logic ref_sel_r;
    logic [3:0] chan_r;
    logic [7:0] cfg_r;
    logic [7:0] result_r;
    logic [3:0] chan_lat_r;
    logic az_lat_r;
    logic [4:0] conv_cnt_r;
    logic [2:0] div_cnt_r;
    logic strobe_d_r;
    logic [7:0] rdata_r;
    logic irq_r;

    logic wr_pri;
    logic wr_cfg;
    logic auto_mode;
    logic strobe_edge;
    logic trigger;
    logic base_tick;
    logic conv_tick;
    logic [4:0] total;
    logic latch_evt;
    logic done_evt;
    logic pending_nxt;
    logic [3:0] chan_nxt;
    logic az_nxt;

    assign wr_pri = mem_wr_i && (mem_addr_i == ADCCTL_PRIMARY_OFS);
    assign wr_cfg = mem_wr_i && (mem_addr_i == ADCCTL_CONFIG_OFS);
    assign auto_mode = cfg_r[ADCCTL_AUTO_BIT];
    assign strobe_edge = pwm_sample_strobe_i && !strobe_d_r;

    // strobe edges during a conversion are dropped, not queued
    always_comb begin
        if (auto_mode) begin
            trigger = strobe_edge && !busy_r;
        end else begin
            trigger = wr_pri && mem_wdata_i[ADCCTL_START_BIT] && !busy_r;
        end
    end

    // timer tick stands in for the conversion clock in auto mode
    assign base_tick = auto_mode ? timer_clk_tick_i : 1'b1;
    assign conv_tick = busy_r && base_tick
        && ((div_cnt_r & div_mask(cfg_r[3:2])) == div_mask(cfg_r[3:2]));
    assign total = az_lat_r ? ADCCTL_AZ_CYCLES : ADCCTL_STD_CYCLES;
    // result lands one conversion cycle before busy drops
    assign latch_evt = conv_tick && (conv_cnt_r == total - 5'h2);
    assign done_evt = conv_tick && (conv_cnt_r == total - 5'h1);

    always_comb begin
        pending_nxt = pending_r;
        if (wr_pri && !mem_wdata_i[ADCCTL_PEND_BIT]) begin
            pending_nxt = 1'b0;
        end
        if (latch_evt) begin
            pending_nxt = 1'b1;
        end
    end

    assign chan_nxt = wr_pri ? mem_wdata_i[3:0] : chan_r;
    assign az_nxt = wr_cfg ? mem_wdata_i[ADCCTL_AZ_BIT] : cfg_r[ADCCTL_AZ_BIT];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pending_r <= ADCCTL_PRIMARY_RST[ADCCTL_PEND_BIT];
        end else begin
            pending_r <= pending_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_en_r <= ADCCTL_PRIMARY_RST[ADCCTL_IRQEN_BIT];
            ref_sel_r <= ADCCTL_PRIMARY_RST[ADCCTL_REF_BIT];
            chan_r <= ADCCTL_PRIMARY_RST[3:0];
        end else if (wr_pri) begin
            irq_en_r <= mem_wdata_i[ADCCTL_IRQEN_BIT];
            ref_sel_r <= mem_wdata_i[ADCCTL_REF_BIT];
            chan_r <= mem_wdata_i[3:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_r <= ADCCTL_CONFIG_RST;
        end else if (wr_cfg) begin
            cfg_r <= mem_wdata_i;
        end
    end

    // only the sequencer clears busy; software zero writes fall through
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            busy_r <= ADCCTL_PRIMARY_RST[ADCCTL_START_BIT];
        end else if (trigger) begin
            busy_r <= 1'b1;
        end else if (done_evt) begin
            busy_r <= 1'b0;
        end
    end

    // selection follows the register while idle, frozen while busy
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            chan_lat_r <= ADCCTL_PRIMARY_RST[3:0];
            az_lat_r <= ADCCTL_CONFIG_RST[ADCCTL_AZ_BIT];
        end else if (!busy_r) begin
            chan_lat_r <= chan_nxt;
            az_lat_r <= az_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            conv_cnt_r <= 5'h00;
        end else if (trigger) begin
            conv_cnt_r <= 5'h00;
        end else if (conv_tick) begin
            conv_cnt_r <= conv_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            div_cnt_r <= 3'h0;
        end else if (trigger) begin
            div_cnt_r <= 3'h0;
        end else if (busy_r && base_tick) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            strobe_d_r <= 1'b0;
        end else begin
            strobe_d_r <= pwm_sample_strobe_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            result_r <= ADCCTL_RESULT_RST;
        end else if (latch_evt) begin
            result_r <= conv_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= pending_nxt && (wr_pri ? mem_wdata_i[ADCCTL_IRQEN_BIT]
                                            : irq_en_r);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_r <= ADCCTL_UNMAPPED_RD;
        end else if (mem_rd_i) begin
            case (mem_addr_i)
                ADCCTL_PRIMARY_OFS: begin
                    rdata_r <= {pending_r, irq_en_r, busy_r, ref_sel_r, chan_r};
                end
                ADCCTL_CONFIG_OFS: begin
                    rdata_r <= cfg_r;
                end
                ADCCTL_RESULT_OFS: begin
                    rdata_r <= result_r;
                end
                default: begin
                    rdata_r <= ADCCTL_UNMAPPED_RD;
                end
            endcase
        end
    end

    assign mem_rdata_o = rdata_r;
    assign conv_done_interrupt_o = irq_r;
    assign conv_active_o = busy_r;
    assign ref_voltage_select_o = ref_sel_r;
    // code goes raw to the mux: 0-3 ch1-4, 8 ch5, 9 gnd, a bandgap, c vcc/3
    assign input_channel_select_o = chan_lat_r;
    assign ref_clock_halve_o = cfg_r[ADCCTL_REFHALF_BIT];
    assign comparator_input_select_o = cfg_r[ADCCTL_CMPSEL_BIT];
    assign spare_amp_enable_o = cfg_r[ADCCTL_AMP_BIT];
    assign current_source_enable_o = cfg_r[ADCCTL_ISRC_BIT];
    assign autozero_enable_o = az_lat_r;
    assign auto_sample_enable_o = cfg_r[ADCCTL_AUTO_BIT];

    sequence s_latch;
        latch_evt;
    endsequence

    sequence s_sw_start;
        !auto_mode && !busy_r && wr_pri && mem_wdata_i[ADCCTL_START_BIT];
    endsequence

    property p_pend_set;
        @(posedge core_clk_i) disable iff (rst_i)
        s_latch |=> pending_r ##0 (result_r == $past(conv_data_i));
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("pending not set with result latch");

    property p_irq;
        @(posedge core_clk_i) disable iff (rst_i)
        ##1 (conv_done_interrupt_o == (pending_r && irq_en_r));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow pending and enable");

    property p_sw_start;
        @(posedge core_clk_i) disable iff (rst_i)
        s_sw_start |=> busy_r ##0 (conv_cnt_r == 5'h00);
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start did not begin a conversion");

    property p_busy_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        busy_r && !done_evt |=> busy_r;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped before conversion end");

    property p_zero_ignored;
        @(posedge core_clk_i) disable iff (rst_i)
        busy_r && !done_evt && wr_pri && !mem_wdata_i[ADCCTL_START_BIT]
            |=> busy_r;
    endproperty
    a_zero_ignored: assert property (p_zero_ignored)
        else $error("software cleared busy mid conversion");

    property p_chan_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        busy_r && $past(busy_r) |-> $stable(input_channel_select_o);
    endproperty
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel selection changed during conversion");

    property p_az_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        busy_r && $past(busy_r) |-> $stable(autozero_enable_o);
    endproperty
    a_az_hold: assert property (p_az_hold)
        else $error("autozero enable changed during conversion");

    property p_pend_keep;
        @(posedge core_clk_i) disable iff (rst_i)
        !latch_evt && wr_pri && mem_wdata_i[ADCCTL_PEND_BIT]
            |=> pending_r == $past(pending_r);
    endproperty
    a_pend_keep: assert property (p_pend_keep)
        else $error("writing one altered pending");

    property p_set_wins;
        @(posedge core_clk_i) disable iff (rst_i)
        latch_evt && wr_pri && !mem_wdata_i[ADCCTL_PEND_BIT] |=> pending_r;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("pending set lost to software clear");

    property p_auto_no_sw;
        @(posedge core_clk_i) disable iff (rst_i)
        auto_mode && !busy_r && !strobe_edge |=> !busy_r;
    endproperty
    a_auto_no_sw: assert property (p_auto_no_sw)
        else $error("conversion started without strobe edge");

    property p_length;
        @(posedge core_clk_i) disable iff (rst_i)
        $fell(busy_r) |-> $past(conv_cnt_r) ==
            ($past(az_lat_r) ? ADCCTL_AZ_CYCLES : ADCCTL_STD_CYCLES) - 5'h1;
    endproperty
    a_length: assert property (p_length)
        else $error("conversion length wrong");

    property p_result_ro;
        @(posedge core_clk_i) disable iff (rst_i)
        !$past(latch_evt) |-> $stable(result_r);
    endproperty
    a_result_ro: assert property (p_result_ro)
        else $error("result changed outside conversion end");

endmodule

//--- verification/adcctl_bench.sv
module adcctl_bench import adcctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] mem_addr_i = 8'h00;
    logic [7:0] mem_wdata_i = 8'h00;
    logic mem_wr_i = 1'b0;
    logic mem_rd_i = 1'b0;
    logic [7:0] mem_rdata_o;
    logic pwm_sample_strobe_i = 1'b0;
    logic timer_clk_tick_i = 1'b1;
    logic [7:0] conv_data_i = 8'h00;
    logic conv_done_interrupt_o, conv_active_o, ref_voltage_select_o;
    logic [3:0] input_channel_select_o;
    logic ref_clock_halve_o, comparator_input_select_o, spare_amp_enable_o;
    logic current_source_enable_o, autozero_enable_o, auto_sample_enable_o;
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hc};

    adcctl_top i_adcctl_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
        .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .mem_rdata_o(mem_rdata_o),
        .pwm_sample_strobe_i(pwm_sample_strobe_i),
        .timer_clk_tick_i(timer_clk_tick_i), .conv_data_i(conv_data_i),
        .conv_done_interrupt_o(conv_done_interrupt_o),
        .conv_active_o(conv_active_o),
        .ref_voltage_select_o(ref_voltage_select_o),
        .input_channel_select_o(input_channel_select_o),
        .ref_clock_halve_o(ref_clock_halve_o),
        .comparator_input_select_o(comparator_input_select_o),
        .spare_amp_enable_o(spare_amp_enable_o),
        .current_source_enable_o(current_source_enable_o),
        .autozero_enable_o(autozero_enable_o),
        .auto_sample_enable_o(auto_sample_enable_o));

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        mem_addr_i = a;
        mem_wdata_i = d;
        mem_wr_i = 1'b1;
        @(negedge core_clk_i);
        mem_wr_i = 1'b0;
    endtask

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_i);
        mem_addr_i = a;
        mem_rd_i = 1'b1;
        @(negedge core_clk_i);
        mem_rd_i = 1'b0;
        check("read data", mem_rdata_o, exp);
    endtask

    // counts cycles of busy seen at falling edges, bounded against hangs
    task automatic run_len(output int len);
        len = 0;
        while (conv_active_o === 1'b1 && len < 2000) begin
            len++;
            @(negedge core_clk_i);
            // timer ticks every other cycle; only auto mode listens
            timer_clk_tick_i = ~timer_clk_tick_i;
        end
    endtask

    function automatic logic [7:0] cfg_out();
        return {ref_clock_halve_o, comparator_input_select_o,
                spare_amp_enable_o, auto_sample_enable_o, 2'b00,
                current_source_enable_o, autozero_enable_o};
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (10) @(negedge core_clk_i);
        rst_i = 1'b0;
        rd(ADCCTL_PRIMARY_OFS, ADCCTL_PRIMARY_RST);
        rd(ADCCTL_CONFIG_OFS, ADCCTL_CONFIG_RST);
        rd(ADCCTL_RESULT_OFS, ADCCTL_RESULT_RST);
        rd(8'h10, ADCCTL_UNMAPPED_RD);
        wr(ADCCTL_CONFIG_OFS, 8'he3);
        check("config pins", cfg_out(), 8'he3);
        rd(ADCCTL_CONFIG_OFS, 8'he3);
        conv_data_i = 8'h5c;
        wr(ADCCTL_PRIMARY_OFS, 8'h6a);
        check("autozero in use", {7'h00, autozero_enable_o}, 8'h01);
        run_len(n);
        check("autozero length", n[7:0], 8'h14);
        check("irq", {7'h00, conv_done_interrupt_o}, 8'h01);
        rd(ADCCTL_PRIMARY_OFS, 8'hca);
        rd(ADCCTL_RESULT_OFS, 8'h5c);
        wr(ADCCTL_PRIMARY_OFS, 8'hca);
        wr(ADCCTL_RESULT_OFS, 8'h00);
        rd(ADCCTL_PRIMARY_OFS, 8'hca);
        rd(ADCCTL_RESULT_OFS, 8'h5c);
        wr(ADCCTL_PRIMARY_OFS, 8'h4a);
        rd(ADCCTL_PRIMARY_OFS, 8'h4a);
        check("irq cleared", {7'h00, conv_done_interrupt_o}, 8'h00);
        wr(ADCCTL_CONFIG_OFS, 8'h00);
        wr(ADCCTL_PRIMARY_OFS, 8'h3c);
        // reference bit rewritten with the value already in use
        wr(ADCCTL_PRIMARY_OFS, 8'h19);
        wr(ADCCTL_CONFIG_OFS, 8'h01);
        check("busy held", {7'h00, conv_active_o}, 8'h01);
        check("chan frozen", {4'h0, input_channel_select_o}, 8'h0c);
        check("az frozen", {7'h00, autozero_enable_o}, 8'h00);
        check("ref", {7'h00, ref_voltage_select_o}, 8'h01);
        rd(ADCCTL_PRIMARY_OFS, 8'h39);
        run_len(n);
        check("irq masked", {7'h00, conv_done_interrupt_o}, 8'h00);
        // selection follows the register from the first idle edge on
        @(negedge core_clk_i);
        check("az idle", {7'h00, autozero_enable_o}, 8'h01);
        wr(ADCCTL_CONFIG_OFS, 8'h00);
        foreach (codes[i]) begin
            wr(ADCCTL_PRIMARY_OFS, {4'h0, codes[i]});
            check("chan", {4'h0, input_channel_select_o}, {4'h0, codes[i]});
            rd(ADCCTL_PRIMARY_OFS, {4'h0, codes[i]});
        end
        wr(ADCCTL_PRIMARY_OFS, 8'h80);
        rd(ADCCTL_PRIMARY_OFS, 8'h00);
        // clear lands on the very edge at which the result is latched
        wr(ADCCTL_PRIMARY_OFS, 8'h20);
        repeat (10) @(negedge core_clk_i);
        wr(ADCCTL_PRIMARY_OFS, 8'h00);
        rd(ADCCTL_PRIMARY_OFS, 8'h80);
        for (int d = 0; d < 4; d++) begin
            wr(ADCCTL_CONFIG_OFS, {4'h0, d[1:0], 2'b00});
            wr(ADCCTL_PRIMARY_OFS, 8'h20);
            run_len(n);
            check("divided length", n[7:0], 8'h0d << d);
        end
        wr(ADCCTL_CONFIG_OFS, 8'h00);
        wr(ADCCTL_CONFIG_OFS, 8'h10);
        check("auto pin", cfg_out(), 8'h10);
        wr(ADCCTL_PRIMARY_OFS, 8'h20);
        check("sw start in auto", {7'h00, conv_active_o}, 8'h00);
        timer_clk_tick_i = 1'b1;
        pwm_sample_strobe_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check("strobe start", {7'h00, conv_active_o}, 8'h01);
        run_len(n);
        // 13 timer ticks: three at full rate, ten every other cycle
        check("auto length", n[7:0], 8'h15);
        repeat (3) @(negedge core_clk_i);
        // a held-high strobe must not retrigger, only a fresh edge does
        check("level no start", {7'h00, conv_active_o}, 8'h00);
        pwm_sample_strobe_i = 1'b0;
        close_out();
    end
endmodule
